// ==== rtl/fecf_controller.v ====
// Purpose: Flash command, unlock and status state machine
// Assumes: Register file write/read strobes on the system clock
// Notes:   Port and CPU share one register path, told apart by PORT_SRC_I
`timescale 1ns/1ps
`include "fecf_consts.vh"

module fecf_controller #(
  parameter ERASE_CYCLES = `FECF_ERASE_NS / `FECF_CLK_NS
) (
  input  wire        CLK_SYS_I,
  input  wire        RST_I,
  input  wire        WR_I,
  input  wire        RD_I,
  input  wire [7:0]  ADDR_I,
  input  wire [7:0]  WDATA_I,
  input  wire        PORT_SRC_I,
  input  wire        PROTECT_OPT_I,
  output reg  [7:0]  RDATA_O,
  output wire        CPU_CLK_HALT_O,
  output wire        PORT_ERASE_DONE_O,
  output wire        FLASH_WE_O,
  output wire        FLASH_INFO_O,
  output wire [15:0] FLASH_ADDR_O,
  output wire [7:0]  FLASH_WDATA_O,
  output wire [7:0]  PAGE_CHOICE_O,
  output wire [7:0]  SECTOR_GUARD_O
);

  // ****************************************
  // States
  // ****************************************
  localparam S_LOCKED   = 3'd0;
  localparam S_UNLK1    = 3'd1;
  localparam S_UNLK2    = 3'd2;
  localparam S_UNLOCKED = 3'd3;
  localparam S_GUARD    = 3'd4;
  localparam S_PAGE_ERS = 3'd5;
  localparam S_MASS_ERS = 3'd6;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [7:0] page_choice_reg;
  reg  [7:0] first_page;
  reg  [7:0] sector_guard;
  reg        port_owner;
  reg        mass_done_seen;
  reg        port_done;
  reg        start;
  reg        mass;
  wire       busy;
  wire       done;

  wire cmd_wr  = WR_I && (ADDR_I == `FECF_ADDR_CMD);
  wire page_wr = WR_I && (ADDR_I == `FECF_ADDR_PAGE);

  // Sector protection decode, used by the erase gate
  function guarded;
    input [7:0] page;
    input [7:0] guard;
    begin
      guarded = guard[page[`FECF_PAGE_MSB:`FECF_SECTOR_LSB]];
    end
  endfunction

  // Info area page erase is allowed only for page 3 from the port
  wire info_pg = page_choice_reg[`FECF_INFO_BIT];
  wire info_ok = PORT_SRC_I && (page_choice_reg == `FECF_INFO_PAGE3) &&
                 (!PROTECT_OPT_I || mass_done_seen);
  wire main_ok = PORT_SRC_I ||
                 !guarded(page_choice_reg, sector_guard);
  wire page_ok = info_pg ? info_ok : main_ok;

  // ****************************************
  // Next-state logic
  // ****************************************
  always @* begin
    next_state = state;
    start      = 1'b0;
    mass       = 1'b0;
    case (state)
      S_LOCKED: begin
        if (cmd_wr) begin
          if (WDATA_I == `FECF_CMD_UNLOCK1)
            next_state = S_UNLK1;
          else if (WDATA_I == `FECF_CMD_GUARD)
            next_state = S_GUARD;
        end
      end
      S_UNLK1: begin
        if (cmd_wr)
          next_state = (WDATA_I == `FECF_CMD_UNLOCK2) ? S_UNLK2 : S_LOCKED;
        else if (page_wr)
          next_state = S_LOCKED;
      end
      S_UNLK2: begin
        if (cmd_wr)
          next_state = S_LOCKED;
        else if (page_wr)
          next_state = (WDATA_I == first_page) ? S_UNLOCKED : S_LOCKED;
      end
      S_UNLOCKED: begin
        if (cmd_wr) begin
          if (WDATA_I == `FECF_CMD_PAGE_ERS && page_ok) begin
            next_state = S_PAGE_ERS;
            start      = 1'b1;
          end else if (WDATA_I == `FECF_CMD_MASS_ERS && PORT_SRC_I) begin
            next_state = S_MASS_ERS;
            start      = 1'b1;
            mass       = 1'b1;
          end else if (WDATA_I == `FECF_CMD_PAGE_ERS ||
                       WDATA_I == `FECF_CMD_MASS_ERS) begin
            // Refused erase leaves the page unlocked, as a wrong source is no bad code
            next_state = S_UNLOCKED;
          end else begin
            next_state = S_LOCKED;
          end
        end else if (page_wr && !PORT_SRC_I) begin
          next_state = S_LOCKED;
        end
      end
      S_GUARD: begin
        if (page_wr)
          next_state = S_LOCKED;
        else if (cmd_wr)
          next_state = S_LOCKED;
      end
      S_PAGE_ERS: begin
        if (done)
          next_state = S_LOCKED;
      end
      S_MASS_ERS: begin
        if (done)
          next_state = S_LOCKED;
      end
      default: next_state = S_LOCKED;
    endcase
  end

  // ****************************************
  // State and shadow registers
  // ****************************************
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state           <= S_LOCKED;
      page_choice_reg <= 8'h00;
      first_page      <= 8'h00;
      sector_guard    <= 8'h00;
      port_owner      <= 1'b0;
      mass_done_seen  <= 1'b0;
      port_done       <= 1'b0;
    end else begin
      state <= next_state;
      if (page_wr && state == S_GUARD)
        sector_guard <= sector_guard | WDATA_I;
      else if (page_wr && state != S_PAGE_ERS && state != S_MASS_ERS)
        page_choice_reg <= WDATA_I;
      if (page_wr && state == S_LOCKED)
        first_page <= WDATA_I;
      if (start)
        port_owner <= PORT_SRC_I;
      if (done && state == S_MASS_ERS)
        mass_done_seen <= 1'b1;
      // Completion flag holds until any erase starts, from the port or the CPU
      if (start)
        port_done <= 1'b0;
      else if (done && port_owner)
        port_done <= 1'b1;
    end
  end

  // ****************************************
  // Status read
  // ****************************************
  reg [5:0] status_code;
  always @* begin
    case (state)
      S_UNLK1:    status_code = `FECF_ST_UNLK1;
      S_UNLK2:    status_code = `FECF_ST_UNLK2;
      S_UNLOCKED: status_code = `FECF_ST_UNLOCKED;
      S_GUARD:    status_code = `FECF_ST_GUARD;
      S_PAGE_ERS: status_code = `FECF_ST_PAGE_ERS;
      S_MASS_ERS: status_code = `FECF_ST_MASS_ERS;
      default:    status_code = `FECF_ST_LOCKED;
    endcase
  end

  // Reads have no side effect on the machine
  always @(posedge CLK_SYS_I) begin
    if (RST_I)
      RDATA_O <= 8'h00;
    else if (RD_I && ADDR_I == `FECF_ADDR_CMD)
      RDATA_O <= {2'b00, status_code};
    else if (RD_I && ADDR_I == `FECF_ADDR_PAGE)
      RDATA_O <= (state == S_GUARD) ? sector_guard : page_choice_reg;
    else
      RDATA_O <= 8'h00;
  end

  // ****************************************
  // Erase engine and outputs
  // ****************************************
  fecf_erase_engine #(
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_engine (
    .CLK_SYS_I   (CLK_SYS_I),
    .RST_I       (RST_I),
    .start_i     (start),
    .mass_i      (mass),
    .page_i      (page_choice_reg),
    .busy_o      (busy),
    .done_o      (done),
    .wipe_we_o   (FLASH_WE_O),
    .wipe_info_o (FLASH_INFO_O),
    .wipe_addr_o (FLASH_ADDR_O),
    .wipe_data_o (FLASH_WDATA_O)
  );

  // Halt only CPU-started work; peripherals keep the system clock
  assign CPU_CLK_HALT_O    = busy && !port_owner;
  assign PORT_ERASE_DONE_O = port_done;
  assign PAGE_CHOICE_O     = page_choice_reg;
  assign SECTOR_GUARD_O    = sector_guard;

endmodule // fecf_controller

// ==== rtl/fecf_consts.vh ====
// Purpose: Constants for the flash erase command state machine
// Assumes: Register file bus with 8-bit address and data, 100 MHz clock
// Notes:   Included by every design file of the block
`ifndef FECF_CONSTS_VH
`define FECF_CONSTS_VH

`define FECF_ADDR_CMD      8'h01
`define FECF_ADDR_PAGE     8'h02
`define FECF_CMD_UNLOCK1   8'h73
`define FECF_CMD_UNLOCK2   8'h8c
`define FECF_CMD_PAGE_ERS  8'h95
`define FECF_CMD_MASS_ERS  8'h63
`define FECF_CMD_GUARD     8'h5e
`define FECF_INFO_PAGE3    8'h83
`define FECF_INFO_BIT      7
`define FECF_PAGE_MSB      6
`define FECF_SECTOR_LSB    4
`define FECF_ST_LOCKED     6'h00
`define FECF_ST_UNLK1      6'h01
`define FECF_ST_UNLK2      6'h02
`define FECF_ST_UNLOCKED   6'h03
`define FECF_ST_GUARD      6'h04
`define FECF_ST_PAGE_ERS   6'h10
`define FECF_ST_MASS_ERS   6'h20
`define FECF_PORT_DONE_BIT 3
`define FECF_PAGE_BYTES    16'h0200
`define FECF_ERASE_NS      10000000
`define FECF_CLK_NS        10
`define FECF_FILL_BYTE     8'hff

`endif

// ==== rtl/fecf_erase_engine.v ====
// Purpose: Timed erase engine that walks flash addresses writing FFH
// Assumes: Flash array accepts one byte write per cycle on the wipe port
// Notes:   Erase time is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "fecf_consts.vh"

module fecf_erase_engine #(
  parameter ERASE_CYCLES = `FECF_ERASE_NS / `FECF_CLK_NS
) (
  input  wire        CLK_SYS_I,
  input  wire        RST_I,
  input  wire        start_i,
  input  wire        mass_i,
  input  wire [7:0]  page_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         wipe_we_o,
  output reg         wipe_info_o,
  output reg  [15:0] wipe_addr_o,
  output wire [7:0]  wipe_data_o
);

  // ****************************************
  // Address walk and erase timer
  // ****************************************
  reg [31:0] timer;
  reg        walking;
  reg [15:0] last_addr;

  assign wipe_data_o = `FECF_FILL_BYTE;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      wipe_we_o   <= 1'b0;
      wipe_info_o <= 1'b0;
      wipe_addr_o <= 16'h0000;
      last_addr   <= 16'h0000;
      timer       <= 32'h0000_0000;
      walking     <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o  <= 1'b1;
        walking <= 1'b1;
        timer   <= ERASE_CYCLES;
        // Mass erase never selects the info area
        wipe_info_o <= mass_i ? 1'b0 : page_i[`FECF_INFO_BIT];
        if (mass_i) begin
          wipe_addr_o <= 16'h0000;
          last_addr   <= 16'hffff;
        end else begin
          // Only the chosen 512-byte page is walked
          wipe_addr_o <= {page_i[`FECF_PAGE_MSB:0], 9'h000};
          last_addr   <= {page_i[`FECF_PAGE_MSB:0], 9'h1ff};
        end
      end else if (busy_o) begin
        wipe_we_o <= walking;
        if (wipe_we_o && wipe_addr_o != last_addr)
          wipe_addr_o <= wipe_addr_o + 16'h0001;
        if (wipe_we_o && wipe_addr_o == last_addr) begin
          walking   <= 1'b0;
          wipe_we_o <= 1'b0;
        end
        if (timer > 32'h0000_0001) begin
          timer <= timer - 32'h0000_0001;
        end else if (!walking) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // fecf_erase_engine

// ==== test/fecf_controller_checker.sv ====
// Purpose: Port assertions for the flash command state machine
// Assumes: One clock, sync active-high reset
// Notes:   Bound to fecf_controller
`timescale 1ns/1ps
module fecf_controller_checker (
  input wire        CLK_SYS_I,
  input wire        RST_I,
  input wire        WR_I,
  input wire        RD_I,
  input wire        PORT_SRC_I,
  input wire [7:0]  ADDR_I,
  input wire [7:0]  RDATA_O,
  input wire        CPU_CLK_HALT_O,
  input wire        PORT_ERASE_DONE_O,
  input wire        FLASH_WE_O,
  input wire        FLASH_INFO_O,
  input wire [15:0] FLASH_ADDR_O,
  input wire [7:0]  FLASH_WDATA_O,
  input wire [7:0]  PAGE_CHOICE_O,
  input wire [7:0]  SECTOR_GUARD_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // ****
  // Checks
  // ****
  rd_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data not idle");
  st_rsv_a: assert property (RD_I && ADDR_I == 8'h01 |=> RDATA_O[7:6] == 2'b00)
    else $error("reserved status bits set");
  st_run_a: assert property (RD_I && ADDR_I == 8'h01 && CPU_CLK_HALT_O |=>
    RDATA_O[5:3] == 3'b010)
    else $error("busy code wrong");
  halt_src_a: assert property ($rose(CPU_CLK_HALT_O) |->
    $past(WR_I) && !$past(PORT_SRC_I))
    else $error("halt without cpu write");
  fill_ones_a: assert property (FLASH_WE_O |-> FLASH_WDATA_O == 8'hff)
    else $error("erase data not ones");
  page_only_a: assert property (CPU_CLK_HALT_O && FLASH_WE_O |->
    FLASH_ADDR_O[15:9] == PAGE_CHOICE_O[6:0] && !FLASH_INFO_O)
    else $error("cpu erase off page");
  done_quiet_a: assert property (PORT_ERASE_DONE_O |-> !FLASH_WE_O)
    else $error("done while writing");
  guard_keep_a: assert property ((SECTOR_GUARD_O & $past(SECTOR_GUARD_O))
    == $past(SECTOR_GUARD_O))
    else $error("guard bit cleared");
  read_quiet_a: assert property (RD_I && !WR_I |=>
    $stable(PAGE_CHOICE_O) && $stable(SECTOR_GUARD_O))
    else $error("read disturbed state");
endmodule // fecf_controller_checker

bind fecf_controller fecf_controller_checker fecf_controller_checker_i (.*);

// ==== test/fecf_flash_model.sv ====
// Purpose: Flash array stand-in tallying erase writes
// Assumes: One byte write per cycle
// Notes:   Main and info writes counted apart
`timescale 1ns/1ps
module fecf_flash_model (
  input  wire        clk_i,
  input  wire        we_i,
  input  wire        info_i,
  input  wire [7:0]  data_i,
  input  wire [15:0] addr_i,
  output reg  [15:0] last_o,
  output reg  [31:0] main_cnt_o,
  output reg  [31:0] info_cnt_o,
  output reg         bad_o
);
  initial begin
    main_cnt_o = 0;
    info_cnt_o = 0;
    last_o = 16'h0000;
    bad_o = 1'b0;
  end
  // ****
  // Array
  // ****
  always @(posedge clk_i) begin
    if (we_i && info_i) info_cnt_o <= info_cnt_o + 1;
    if (we_i && !info_i) main_cnt_o <= main_cnt_o + 1;
    if (we_i) last_o <= addr_i;
    if (we_i && data_i !== 8'hff) bad_o <= 1'b1;
  end
endmodule // fecf_flash_model

// ==== test/tb_flash_erase_command_fsm.sv ====
// Purpose: Self-checking bench for the flash command state machine
// Assumes: Inputs driven on the falling edge
// Notes:   Erase time cut to 600 cycles
`timescale 1ns/1ps
module tb_flash_erase_command_fsm;
  reg         CLK_SYS_I = 1'b0;
  reg         RST_I = 1'b1;
  reg         WR_I = 1'b0;
  reg         RD_I = 1'b0;
  reg         PORT_SRC_I = 1'b0;
  reg         PROTECT_OPT_I = 1'b0;
  reg  [7:0]  ADDR_I = 8'h00;
  reg  [7:0]  WDATA_I = 8'h00;
  wire [7:0]  RDATA_O, PAGE_CHOICE_O, SECTOR_GUARD_O, FLASH_WDATA_O;
  wire [15:0] FLASH_ADDR_O, last;
  wire        CPU_CLK_HALT_O, PORT_ERASE_DONE_O, FLASH_WE_O, FLASH_INFO_O, bad;
  wire [31:0] cnt, icnt;
  integer     mismatches = 0, checks = 0, st = 0, em = 0, ei = 0, k, fp = 0;
  reg  [31:0] r = 32'h3092;

  fecf_controller #(.ERASE_CYCLES(600)) fecf_controller_i (.*);
  fecf_flash_model fecf_flash_model_i (.clk_i(CLK_SYS_I), .we_i(FLASH_WE_O),
    .info_i(FLASH_INFO_O), .data_i(FLASH_WDATA_O), .addr_i(FLASH_ADDR_O),
    .main_cnt_o(cnt), .info_cnt_o(icnt), .last_o(last), .bad_o(bad));

  always #5 CLK_SYS_I = ~CLK_SYS_I;
  // ****
  // Tasks
  // ****
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  function [31:0] lfsr(input [31:0] v);
    begin
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    end
  endfunction
  // Model follows each write; erase outcomes are set by ers
  task wr(input [7:0] a, input [7:0] d, input s);
    begin
      @(negedge CLK_SYS_I);
      {WR_I, ADDR_I, WDATA_I, PORT_SRC_I} = {1'b1, a, d, s};
      @(negedge CLK_SYS_I);
      WR_I = 1'b0;
      if (a == 8'h02) begin
        // Own copy of the first page, never the design's register
        if (st == 0) fp = d;
        st = (st == 2 && d == fp) ? 3 : (st == 3 && s) ? 3 : 0;
      end else if (st == 0) st = (d == 8'h73) ? 1 : (d == 8'h5e) ? 4 : 0;
      else if (st == 1) st = (d == 8'h8c) ? 2 : 0;
      else st = (st == 3 && (d == 8'h95 || d == 8'h63)) ? 3 : 0;
    end
  endtask
  task rd;
    begin
      @(negedge CLK_SYS_I);
      {RD_I, ADDR_I} = {1'b1, 8'h01};
      @(negedge CLK_SYS_I);
      RD_I = 1'b0;
    end
  endtask
  task rdc;
    begin
      rd;
      chk(RDATA_O, st);
    end
  endtask
  task unl(input [7:0] p, input s);
    begin
      // Relock first: a refused erase leaves the machine unlocked
      wr(8'h01, 8'h00, s);
      wr(8'h02, p, s);
      wr(8'h01, 8'h73, s);
      rdc;
      wr(8'h01, 8'h8c, s);
      rdc;
      wr(8'h02, p, s);
      rdc;
    end
  endtask
  // Code 03 means refused: nothing may be written
  task ers(input [7:0] d, input s, input [7:0] code, input integer nm, input integer ni,
           input [15:0] la);
    begin
      wr(8'h01, d, s);
      st = code;
      rd;
      if (code == 8'h03) begin
        chk(RDATA_O, st);
      end else begin
        // Only the upper code bits carry meaning while busy
        chk(RDATA_O[7:3], code[7:3]);
        chk(CPU_CLK_HALT_O, !s);
        chk(PORT_ERASE_DONE_O, 1'b0);
        for (k = 0; k < 40000; k = k + 1) begin
          rd;
          if (RDATA_O[5:3] === 3'b000) k = 40000;
        end
        st = 0;
        rdc;
        chk(PORT_ERASE_DONE_O, s);
        chk(CPU_CLK_HALT_O, 1'b0);
        chk(last, la);
      end
      em = em + nm;
      ei = ei + ni;
      chk(cnt, em);
      chk(icnt, ei);
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    repeat (5) @(negedge CLK_SYS_I);
    RST_I = 1'b0;
    rdc;
    unl(8'h25, 1'b0);
    ers(8'h95, 1'b0, 8'h10, 512, 0, 16'h4bff);
    for (k = 0; k < 6; k = k + 1) begin
      r = lfsr(r);
      wr(8'h01, 8'h73, 1'b0);
      wr(8'h01, (r[7:0] == 8'h8c) ? 8'h00 : r[7:0], r[8]);
      rdc;
    end
    wr(8'h01, 8'h95, 1'b0);
    rdc;
    wr(8'h02, 8'h11, 1'b0);
    wr(8'h01, 8'h73, 1'b0);
    wr(8'h01, 8'h8c, 1'b0);
    wr(8'h02, 8'h12, 1'b0);
    rdc;
    unl(8'h25, 1'b0);
    ers(8'h63, 1'b0, 8'h03, 0, 0, 16'h0000);
    wr(8'h02, 8'h25, 1'b1);
    rdc;
    wr(8'h02, 8'h25, 1'b0);
    rdc;
    wr(8'h01, 8'h5e, 1'b0);
    rdc;
    wr(8'h02, 8'h04, 1'b0);
    chk(SECTOR_GUARD_O, 8'h04);
    chk(PAGE_CHOICE_O, 8'h25);
    wr(8'h01, 8'h00, 1'b0);
    unl(8'h25, 1'b0);
    ers(8'h95, 1'b0, 8'h03, 0, 0, 16'h0000);
    unl(8'h25, 1'b1);
    ers(8'h95, 1'b1, 8'h10, 512, 0, 16'h4bff);
    PROTECT_OPT_I = 1'b1;
    unl(8'h83, 1'b0);
    ers(8'h95, 1'b0, 8'h03, 0, 0, 16'h0000);
    unl(8'h83, 1'b1);
    ers(8'h95, 1'b1, 8'h03, 0, 0, 16'h0000);
    unl(8'h00, 1'b1);
    ers(8'h63, 1'b1, 8'h20, 65536, 0, 16'hffff);
    unl(8'h83, 1'b1);
    ers(8'h95, 1'b1, 8'h10, 0, 512, 16'h07ff);
    chk(bad, 1'b0);
    final_report;
  end
endmodule // tb_flash_erase_command_fsm
